// >>> rtl/adc_ctrl_pkg.sv
`default_nettype none

package adc_ctrl_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_RESULT_LOW = 8'h24;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h25;
    localparam logic [7:0] IDX_CONTROL = 8'h26;
    localparam logic [7:0] IDX_CLOCK_SETTING = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h29;

    // Control register fields
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_PENDING_BIT = 6;
    localparam int CTRL_CFG_LSB = 3;
    localparam int CTRL_CHAN_LSB = 0;

    // Clock setting register fields
    localparam int CLKSET_TEST_BIT = 7;
    localparam int CLKSET_DIV_LSB = 0;

    // Result layout: high byte holds bits 9..2, low byte bits 1..0 at 7..6
    localparam int RESULT_LOW_LSB = 6;
    localparam int RESULT_WIDTH = 10;

    // Interrupt status and mask layout
    localparam int IRQ_DONE_BIT = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CLKSET_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Conversion clock divider codes and terminal counts (divide minus one)
    localparam logic [1:0] DIV_CODE_2 = 2'h0;
    localparam logic [1:0] DIV_CODE_8 = 2'h1;
    localparam logic [1:0] DIV_CODE_32 = 2'h2;
    localparam logic [4:0] DIV_LAST_2 = 5'h01;
    localparam logic [4:0] DIV_LAST_8 = 5'h07;
    localparam logic [4:0] DIV_LAST_32 = 5'h1F;

    // Conversion clocks spent sampling, and per result bit while settling
    localparam logic [2:0] SAMPLE_TICKS_LAST = 3'h3;
    localparam logic [2:0] STEP_TICKS_LAST = 3'h3;
    localparam logic [3:0] TOP_BIT = 4'h9;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HOLD = 4'h2,
        ST_SAMPLE = 4'h4,
        ST_CONVERT = 4'h8
    } conv_state_type;

endpackage

`default_nettype wire

// >>> rtl/adc_conversion_control.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmp_above_i,
    output logic [9:0] dac_code_o,
    output logic [2:0] channel_sel_o,
    output logic [7:0] port_analog_o,
    output logic adc_power_o,
    output logic sampling_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Number of analog lines grows with the configuration code; 7 takes all 8
    // Lines are taken from line zero upward, so the low channels are the
    // first to lose their digital function
    function automatic logic [7:0] analog_lines(input logic [2:0] cfg);
        logic [7:0] mask;
        mask = 8'h00;
        case (cfg)
            3'h0: mask = 8'h00;
            3'h1: mask = 8'h01;
            3'h2: mask = 8'h03;
            3'h3: mask = 8'h07;
            3'h4: mask = 8'h0F;
            3'h5: mask = 8'h1F;
            3'h6: mask = 8'h3F;
            default: mask = 8'hFF;
        endcase
        return mask;
    endfunction

    // Terminal count of the conversion clock divider
    // The undefined code gets the slowest clock rather than none, so a stray
    // setting still finishes a conversion
    function automatic logic [4:0] div_last(input logic [1:0] code);
        logic [4:0] last;
        last = adc_ctrl_pkg::DIV_LAST_32;
        case (code)
            adc_ctrl_pkg::DIV_CODE_2: last = adc_ctrl_pkg::DIV_LAST_2;
            adc_ctrl_pkg::DIV_CODE_8: last = adc_ctrl_pkg::DIV_LAST_8;
            adc_ctrl_pkg::DIV_CODE_32: last = adc_ctrl_pkg::DIV_LAST_32;
            default: last = adc_ctrl_pkg::DIV_LAST_32; // Undefined code runs slowest
        endcase
        return last;
    endfunction

    // Register index from a word-aligned byte address
    function automatic logic [7:0] reg_index(input logic [7:0] adr);
        return {2'h0, adr[7:2]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        // Sequencer phase, start bit history and the pending flag
        adc_ctrl_pkg::conv_state_type state;
        logic start;
        logic pending;
        // Software fields of the control and clock setting registers
        logic [2:0] port_cfg;
        logic [2:0] chan;
        logic [1:0] div_code;
        logic test; // Stored and read back only; it drives nothing
        // Last finished result, held until the next completion
        logic [9:0] result;
        // Working code under trial and the bit being decided
        logic [9:0] sar;
        logic [3:0] bit_idx;
        // Conversion clock prescaler and ticks spent in the current phase
        logic [4:0] div_cnt;
        logic [2:0] tick_cnt;
        // Comparator synchroniser and its accepted level
        logic [2:0] cmp_sync;
        logic cmp_val;
        // Completion interrupt: sticky status and its mask
        logic irq_sts;
        logic irq_mask;
        // Bus answer and its registered read data
        logic ack;
        logic [7:0] rdata;
        // Registered copies of the pin-side outputs
        logic irq;
        logic power;
        logic [7:0] analog;
        logic sampling;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    logic bus_req;
    logic wr_en;
    logic [7:0] idx;
    logic tick;
    logic conv_done;

    // A request is taken only while ack is low, so a master that keeps its
    // strobe up through the answer cycle is not served twice; writes need
    // byte lane zero, the only lane that carries register bits
    assign bus_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
    assign idx = reg_index(wb_adr_i);

    // Conversion clock tick; comparing at-or-above lets a smaller divider
    // chosen mid-count take effect at once instead of after a counter wrap
    assign tick = (s_r.div_cnt >= div_last(s_r.div_code));

    // Last bit decision of a conversion; the status clear below needs it so
    // that a completion and a clear in the same cycle leave the bit set
    assign conv_done = (s_r.state == adc_ctrl_pkg::ST_CONVERT) && tick
        && (s_r.tick_cnt == adc_ctrl_pkg::STEP_TICKS_LAST) && (s_r.bit_idx == 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_nxt = s_r;

        // Comparator crosses in from the analog side: three stages, agree to accept
        // The first stage may go metastable and is read only by the second;
        // a level that flips between stages keeps the previous decision
        s_nxt.cmp_sync = {s_r.cmp_sync[1:0], cmp_above_i};
        if (s_r.cmp_sync[1] == s_r.cmp_sync[2]) begin
            s_nxt.cmp_val = s_r.cmp_sync[2];
        end

        // Conversion clock prescaler, free running between conversions
        // A launch restarts it, so every conversion has the same length
        if (tick) begin
            s_nxt.div_cnt = 5'h00;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 5'h01;
        end

        // Converter sequencer: held in reset while start is high, then a fixed
        // sampling phase, then one trial per result bit from the top down; the
        // trial code goes straight out so the comparator sees it next cycle
        case (s_r.state)
            adc_ctrl_pkg::ST_IDLE: begin
                s_nxt.sampling = 1'b0;
            end
            adc_ctrl_pkg::ST_HOLD: begin
                // Held in reset while the start bit stays high
                s_nxt.sampling = 1'b0;
                s_nxt.sar = 10'h000;
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
                s_nxt.sampling = 1'b1;
                if (tick) begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 3'h1;
                    if (s_r.tick_cnt == adc_ctrl_pkg::SAMPLE_TICKS_LAST) begin
                        s_nxt.tick_cnt = 3'h0;
                        s_nxt.sampling = 1'b0;
                        s_nxt.bit_idx = adc_ctrl_pkg::TOP_BIT;
                        s_nxt.sar = 10'h200; // Trial the top bit first
                        s_nxt.state = adc_ctrl_pkg::ST_CONVERT;
                    end
                end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                // Several conversion clocks per bit so the synchroniser can settle
                if (tick) begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 3'h1;
                    if (s_r.tick_cnt == adc_ctrl_pkg::STEP_TICKS_LAST) begin
                        s_nxt.tick_cnt = 3'h0;
                        if (!s_r.cmp_val) begin
                            s_nxt.sar[s_r.bit_idx] = 1'b0;
                        end
                        if (s_r.bit_idx == 4'h0) begin
                            // Result lands on the same edge the flag drops
                            s_nxt.result = s_nxt.sar;
                            s_nxt.pending = 1'b0;
                            s_nxt.irq_sts = 1'b1;
                            s_nxt.state = adc_ctrl_pkg::ST_IDLE;
                        end else begin
                            s_nxt.bit_idx = s_r.bit_idx - 4'h1;
                            s_nxt.sar[s_r.bit_idx - 4'h1] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_nxt.state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase

        // Register writes; the result bytes ignore writes entirely
        if (wr_en) begin
            case (idx)
                adc_ctrl_pkg::IDX_CONTROL: begin
                    s_nxt.chan = wb_dat_i[adc_ctrl_pkg::CTRL_CHAN_LSB +: 3];
                    s_nxt.port_cfg = wb_dat_i[adc_ctrl_pkg::CTRL_CFG_LSB +: 3];
                    s_nxt.start = wb_dat_i[adc_ctrl_pkg::CTRL_START_BIT];
                    if (!s_r.start && wb_dat_i[adc_ctrl_pkg::CTRL_START_BIT]) begin
                        // Rising edge aborts any conversion and arms the flag
                        s_nxt.pending = 1'b1;
                        s_nxt.state = adc_ctrl_pkg::ST_HOLD;
                        s_nxt.sampling = 1'b0;
                        s_nxt.tick_cnt = 3'h0;
                    end else if (s_r.start && !wb_dat_i[adc_ctrl_pkg::CTRL_START_BIT]) begin
                        // Falling edge completes the pulse and launches
                        s_nxt.state = adc_ctrl_pkg::ST_SAMPLE;
                        s_nxt.tick_cnt = 3'h0;
                        s_nxt.div_cnt = 5'h00;
                        s_nxt.sar = 10'h000;
                    end
                end
                adc_ctrl_pkg::IDX_CLOCK_SETTING: begin
                    s_nxt.div_code = wb_dat_i[adc_ctrl_pkg::CLKSET_DIV_LSB +: 2];
                    s_nxt.test = wb_dat_i[adc_ctrl_pkg::CLKSET_TEST_BIT];
                end
                adc_ctrl_pkg::IDX_IRQ_STATUS: begin
                    // Write one to clear, but a completion on this edge wins
                    if (wb_dat_i[adc_ctrl_pkg::IRQ_DONE_BIT] && !conv_done) begin
                        s_nxt.irq_sts = 1'b0;
                    end
                end
                adc_ctrl_pkg::IDX_IRQ_MASK: begin
                    s_nxt.irq_mask = wb_dat_i[adc_ctrl_pkg::IRQ_DONE_BIT];
                end
                default: begin
                    s_nxt.irq_mask = s_r.irq_mask; // Unmapped and read-only: no effect
                end
            endcase
        end

        // Read data captured on the edge that raises ack
        // Data is registered with ack, so it stands exactly in the answer cycle;
        // unmapped indices read zero
        s_nxt.ack = bus_req;
        if (bus_req) begin
            case (idx)
                adc_ctrl_pkg::IDX_RESULT_LOW: begin
                    s_nxt.rdata = {s_r.result[1:0], 6'h00};
                end
                adc_ctrl_pkg::IDX_RESULT_HIGH: begin
                    s_nxt.rdata = s_r.result[9:2];
                end
                adc_ctrl_pkg::IDX_CONTROL: begin
                    s_nxt.rdata = {s_r.start, s_r.pending, s_r.port_cfg, s_r.chan};
                end
                adc_ctrl_pkg::IDX_CLOCK_SETTING: begin
                    s_nxt.rdata = {s_r.test, 5'h00, s_r.div_code};
                end
                adc_ctrl_pkg::IDX_IRQ_STATUS: begin
                    s_nxt.rdata = {7'h00, s_r.irq_sts};
                end
                adc_ctrl_pkg::IDX_IRQ_MASK: begin
                    s_nxt.rdata = {7'h00, s_r.irq_mask};
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Pin-side controls follow the next register values, so outputs track writes
        // Taking them from the next value costs a little logic but puts the pin
        // change on the same edge as the bus answer
        s_nxt.analog = analog_lines(s_nxt.port_cfg);
        s_nxt.power = (s_nxt.port_cfg != 3'h0);
        s_nxt.irq = s_nxt.irq_sts & s_nxt.irq_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // Every field is listed under reset, with constants only, so the record
    // leaves reset fully known

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.state <= adc_ctrl_pkg::ST_IDLE;
            s_r.start <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::CTRL_START_BIT];
            s_r.pending <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::CTRL_PENDING_BIT];
            s_r.port_cfg <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::CTRL_CFG_LSB +: 3];
            s_r.chan <= adc_ctrl_pkg::CONTROL_RESET[adc_ctrl_pkg::CTRL_CHAN_LSB +: 3];
            s_r.div_code <= adc_ctrl_pkg::CLKSET_RESET[adc_ctrl_pkg::CLKSET_DIV_LSB +: 2];
            s_r.test <= adc_ctrl_pkg::CLKSET_RESET[adc_ctrl_pkg::CLKSET_TEST_BIT];
            s_r.result <= adc_ctrl_pkg::RESULT_RESET;
            s_r.sar <= 10'h000;
            s_r.bit_idx <= 4'h0;
            s_r.div_cnt <= 5'h00;
            s_r.tick_cnt <= 3'h0;
            s_r.cmp_sync <= 3'h0;
            s_r.cmp_val <= 1'b0;
            s_r.irq_sts <= 1'b0;
            s_r.irq_mask <= 1'b0;
            s_r.ack <= 1'b0;
            s_r.rdata <= 8'h00;
            s_r.irq <= 1'b0;
            s_r.power <= 1'b0;
            s_r.analog <= 8'h00;
            s_r.sampling <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register
    // The upper read-data bytes are constant zero; the registers are one byte wide

    assign wb_dat_o = {24'h000000, s_r.rdata};
    assign wb_ack_o = s_r.ack;
    assign dac_code_o = s_r.sar;
    assign channel_sel_o = s_r.chan;
    assign port_analog_o = s_r.analog;
    assign adc_power_o = s_r.power;
    assign sampling_o = s_r.sampling;
    assign irq_o = s_r.irq;

endmodule

`default_nettype wire

// >>> verif/adc_conv_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conv_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmp_above_i,
    input wire logic [9:0] dac_code_o,
    input wire logic [2:0] channel_sel_o,
    input wire logic [7:0] port_analog_o,
    input wire logic adc_power_o,
    input wire logic sampling_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Configuration 7 turns all eight lines analog, not seven
    function automatic logic [7:0] lines_of(input logic [2:0] c);
        return (c == 3'h7) ? 8'hFF : ((8'h01 << c) - 8'h01);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ctrl_write;
        req_taken ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h26);
    endsequence
    sequence read_of(logic [5:0] idx);
        req_taken ##0 (!wb_we_i && wb_adr_i[7:2] == idx);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_ack_after_req: assert property (req_taken |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    chk_chan_follow: assert property (
        ctrl_write |=> channel_sel_o == $past(wb_dat_i[2:0]))
        else $error("channel select does not follow control write");
    chk_port_lines: assert property (
        ctrl_write |=> port_analog_o == lines_of($past(wb_dat_i[5:3])))
        else $error("analog line map wrong");
    chk_power_cfg: assert property (
        ctrl_write |=> adc_power_o == (|$past(wb_dat_i[5:3])))
        else $error("converter power does not follow configuration");
    chk_power_lines: assert property (adc_power_o == (port_analog_o != 8'h00))
        else $error("power and analog lines disagree");
    chk_clkset_zero: assert property (read_of(6'h27) |=> wb_dat_o[6:2] == 5'h00)
        else $error("clock setting unused bits not zero");
    chk_low_layout: assert property (read_of(6'h24) |=> wb_dat_o[5:0] == 6'h00)
        else $error("result low byte unused bits not zero");
endmodule
bind adc_conversion_control adc_conv_properties adc_conv_properties_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_above_i(cmp_above_i), .dac_code_o(dac_code_o),
    .channel_sel_o(channel_sel_o), .port_analog_o(port_analog_o),
    .adc_power_o(adc_power_o), .sampling_o(sampling_o), .irq_o(irq_o));
`default_nettype wire

// >>> verif/analog_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_src_model (
    input wire logic clk_i,
    input wire logic [9:0] dac_code_i,
    input wire logic [2:0] channel_i,
    input wire logic [7:0] port_analog_i,
    input wire logic power_i,
    input wire logic [7:0][9:0] level_i,
    output logic cmp_above_o
);
    logic noise_r = 1'b0;
    // A line left digital or unpowered gives no usable level, so it toggles
    always @(posedge clk_i) begin
        noise_r <= ~noise_r;
    end
    // Source sits half a step above its level, so the ideal result is the level
    assign cmp_above_o = (power_i && port_analog_i[channel_i]) ?
        (dac_code_i <= level_i[channel_i]) : noise_r;
endmodule
`default_nettype wire

// >>> verif/adc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cmp, pwr, irq, smp;
    logic [7:0] adr = 8'h00, ports;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdo, rd;
    logic ack;
    logic [9:0] dac;
    logic [2:0] chs;
    logic [7:0][9:0] lvl = '0;
    logic [15:0] lf = 16'hDE11;
    int err_total = 0, num_checks = 0, n, k, ch, cfg, msk, ev, cyc_exp;
    int exp_q[$];
    logic [7:0] base;
    always #50 clk_i = ~clk_i;
    adc_conversion_control adc_conversion_control_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .cmp_above_i(cmp),
        .dac_code_o(dac), .channel_sel_o(chs), .port_analog_o(ports), .adc_power_o(pwr),
        .sampling_o(smp), .irq_o(irq));
    analog_src_model analog_src_model_i (.clk_i(clk_i), .dac_code_i(dac), .channel_i(chs),
        .port_analog_i(ports), .power_i(pwr), .level_i(lvl), .cmp_above_o(cmp));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; ack is sampled at a rising edge, released at that same edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int t;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx[5:0], 2'b00};
        wdat <= {24'h000000, d};
        for (t = 0; t < 50; t++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (t == 50) begin
            err_total++;
            end_sim();
        end
        rd = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Every output is low coming out of reset
        @(posedge clk_i);
        check({dac, chs, ports, pwr, smp, irq}, 32'h0);
        // Reset values, plus an unmapped index that must read zero
        for (k = 0; k < 7; k++) begin
            xfer(1'b0, (k == 6) ? 8'h00 : 8'h24 + k[7:0], 8'h00);
            check(rd, 32'h0);
        end
        xfer(1'b1, adc_ctrl_pkg::IDX_RESULT_LOW, 8'hFF);
        xfer(1'b1, adc_ctrl_pkg::IDX_RESULT_HIGH, 8'hFF);
        xfer(1'b0, adc_ctrl_pkg::IDX_RESULT_HIGH, 8'h00);
        check(rd, 32'h0);
        for (k = 0; k < 6; k++) begin
            lf = lfsr_next(lf);
            ch = lf[2:0];
            cfg = (ch >= 6) ? 7 : ch + 1;
            msk = lf[3];
            lvl[ch] <= lf[15:6];
            exp_q.push_back(lf[15:6]);
            base = {2'b00, cfg[2:0], lf[2:0]};
            xfer(1'b1, adc_ctrl_pkg::IDX_CLOCK_SETTING, 8'h7C | 8'(k % 3));
            xfer(1'b0, adc_ctrl_pkg::IDX_CLOCK_SETTING, 8'h00);
            check(rd, k % 3);
            xfer(1'b1, adc_ctrl_pkg::IDX_IRQ_MASK, msk[7:0]);
            xfer(1'b1, adc_ctrl_pkg::IDX_CONTROL, base);
            xfer(1'b1, adc_ctrl_pkg::IDX_CONTROL, base | 8'h80);
            xfer(1'b0, adc_ctrl_pkg::IDX_CONTROL, 8'h00);
            check(rd[6], 1);
            if (k == 1) begin
                // A rise alone holds the converter in reset: nothing completes
                repeat (300) @(posedge clk_i);
                xfer(1'b0, adc_ctrl_pkg::IDX_CONTROL, 8'h00);
                check(rd[6], 1);
            end
            xfer(1'b1, adc_ctrl_pkg::IDX_CONTROL, base);
            check({chs, ports, pwr}, {lf[2:0], (cfg == 7) ? 8'hFF : 8'hFF >> (8 - cfg),
                1'b1});
            @(posedge clk_i);
            check(smp, 1);
            for (n = 0; n < 3000; n++) begin
                xfer(1'b0, adc_ctrl_pkg::IDX_CONTROL, 8'h00);
                if (rd[6] === 1'b0) break;
            end
            check(rd[6], 0);
            if (rd[6] !== 1'b0) end_sim();
            // Launch to completion: fixed tick counts at the selected divider
            cyc_exp = (adc_ctrl_pkg::SAMPLE_TICKS_LAST + 1 + (adc_ctrl_pkg::TOP_BIT + 1)
                * (adc_ctrl_pkg::STEP_TICKS_LAST + 1)) * (2 << (2 * (k % 3)));
            check((n * 3 + 6 >= cyc_exp) && (n * 3 <= cyc_exp + 6), 1);
            lvl[ch] <= ~lf[15:6];
            repeat (200) @(posedge clk_i);
            xfer(1'b0, adc_ctrl_pkg::IDX_RESULT_HIGH, 8'h00);
            base = rd[7:0];
            xfer(1'b0, adc_ctrl_pkg::IDX_RESULT_LOW, 8'h00);
            ev = exp_q.pop_front();
            check({base, rd[7:6]}, ev);
            check({smp, dac}, ev);
            check(irq, msk);
            xfer(1'b1, adc_ctrl_pkg::IDX_IRQ_STATUS, 8'h01);
            xfer(1'b0, adc_ctrl_pkg::IDX_IRQ_STATUS, 8'h00);
            check({rd[0], irq}, 0);
        end
        xfer(1'b1, adc_ctrl_pkg::IDX_CONTROL, 8'h05);
        check({pwr, ports}, 0);
        end_sim();
    end
endmodule
`default_nettype wire
